/* File: testbench.sv */
// Self-checking bench of the frame, baud and infrared configuration block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clock = 1'b0;  // 200 MHz
	logic        rst_n = 1'b0;  // Sync reset
	logic        wr    = 1'b0;  // Write strobe
	logic        rd    = 1'b0;  // Read strobe
	logic        halt  = 1'b0;  // Debug halt
	logic        fire  = 1'b0;  // Partner command
	logic        evt   = 1'b0;  // Event level
	logic        bit_in = 1'b0; // Transmit bit
	logic [3:0]  addr  = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  len   = 8'h00;
	logic [7:0]  rdata, sync_len;
	logic [1:0]  rxm, cm;
	logic [3:0]  dbits;
	logic        irq, multiprocessor_enable, spi, ir, pen, podd, stop2, nhf, lsb, trail, aben;
	logic        acc, run, irrx, stick, btick, irtxd, sync_valid, ir_event, tx_bit;
	logic [31:0] seed = 32'h0001472E; // Fixed seed
	logic [7:0]  tol [4] = '{8'h06, 8'h05, 8'h07, 8'h08};
	logic [7:0]  r, v;
	int          mismatches = 0;
	int          n_compared = 0;
	int          n;
	usfc_top usfc_top_i (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .DEBUG_HALT(halt),
		.SYNC_VALID(sync_valid), .SYNC_LEN(sync_len), .IR_EVENT_IN(ir_event),
		.TX_BIT(tx_bit), .MULTIPROCESSOR_ENABLE_EN(multiprocessor_enable), .RX_MODE(rxm), .COMM_MODE(cm), .SPI_MODE(spi),
		.IR_MODE(ir), .PARITY_EN(pen), .PARITY_ODD(podd), .STOP_TWO(stop2),
		.DATA_BITS(dbits), .NINE_HIGH_FIRST(nhf), .SPI_LSB_FIRST(lsb),
		.SPI_SAMPLE_TRAIL(trail), .AUTOBAUD_EN(aben), .SYNC_ACCEPT(acc), .RUN_EN(run),
		.IR_RX_IN(irrx), .SAMPLE_TICK(stick), .BIT_TICK(btick), .IR_TXD(irtxd));
	usfc_far_model usfc_far_model_i (.clk(clock), .rst_n(rst_n), .fire(fire), .len(len),
		.evt(evt), .bit_in(bit_in), .sync_valid(sync_valid), .sync_len(sync_len),
		.ir_event(ir_event), .tx_bit(tx_bit));
	// Clock
	always #2.5 clock = ~clock;
	// Xorshift step
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// Compare and count
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	// Verdict and end of run
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	// One-cycle register write
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wreg
	// One-cycle read, data taken in the following cycle
	task automatic rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask : rreg
	// Frame write with expected decode
	task automatic frame_case(input logic [7:0] f);
		logic s;
		logic [7:0] q;
		s = (f[7:6] == 2'h3);
		wreg(4'h7, f);
		repeat (3) @(posedge clock);
		#1;
		check("comm", f[7:6], cm);
		check("spi", s, spi);
		check("ir", f[7:6] == 2'h2, ir);
		check("par_en", !s && f[5], pen);
		check("par_odd", !s && f[5:4] == 2'h3, podd);
		check("stop", !s && f[3], stop2);
		check("lsb", s && f[2], lsb);
		check("trail", s && f[1], trail);
		if (!s) begin
			check("bits", f[2] ? 4'h9 : 4'(f[1:0]) + 4'h5, dbits);
			check("nine_hi", f[2:0] == 3'h7, nhf);
		end
		rreg(4'h7, q);
		check("frame_rd", s ? f & 8'hC6 : f, q);
	endtask : frame_case
	// Sync measurement through the partner
	task automatic sync_try(input logic [7:0] l, input logic ea, input logic ef);
		int k;
		logic [7:0] q;
		k = 0;
		@(posedge clock);
		fire <= 1'b1;
		len <= l;
		@(posedge clock);
		fire <= 1'b0;
		repeat (6) begin
			@(negedge clock);
			k += acc;
		end
		check("accept", ea, k);
		rreg(4'h4, q);
		check("sync_flag", ef, q[3]);
		check("irq", ef, irq);
		wreg(4'h4, 8'h08);
	endtask : sync_try
	// Cycles between two pulses of a tick
	task automatic gap(input logic b, output int p);
		int k;
		k = 0;
		p = 0;
		// Leave the launching edge before looking at the tick
		@(negedge clock);
		while ((b ? btick : stick) !== 1'b1 && k < 5000) begin
			@(negedge clock);
			k++;
		end
		do begin
			@(negedge clock);
			p++;
		end while ((b ? btick : stick) !== 1'b1 && p < 5000);
	endtask : gap
	// Transmit line copies the bit one cycle later
	task automatic pass_run();
		logic p;
		@(negedge clock);
		p = tx_bit;
		repeat (40) begin
			@(posedge clock);
			seed = xs(seed);
			bit_in <= seed[0];
			@(negedge clock);
			check("txd_pass", p, irtxd);
			p = tx_bit;
		end
	endtask : pass_run
	// Length of one whole high pulse on the transmit line
	task automatic runlen(output int p);
		int k;
		k = 0;
		p = 0;
		@(negedge clock);
		while (irtxd !== 1'b0 && k < 500) begin
			@(negedge clock);
			k++;
		end
		while (irtxd !== 1'b1 && k < 1000) begin
			@(negedge clock);
			k++;
		end
		while (irtxd === 1'b1 && p < 500) begin
			@(negedge clock);
			p++;
		end
	endtask : runlen
	// Watchdog, about ten times the expected run
	initial begin
		#80000;
		mismatches++;
		complete_run();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		for (int a = 0; a < 16; a++) begin
			rreg(4'(a), r);
			check("reset_rd", a == 7 ? 8'h03 : 8'h00, r);
		end
		check("reset_bits", 4'h8, dbits);
		check("reset_run", 1'b1, run);
		wreg(4'h0, 8'hFF);
		rreg(4'h0, r);
		check("unmapped", 8'h00, r);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			v = seed[7:0];
			if (i < 4)
				v[7:6] = 2'(i);
			if (v[5:4] == 2'h1)
				v[5:4] = 2'h2;
			if (v[2:1] == 2'b10)
				v[1] = 1'b1;
			frame_case(v);
		end
		$display("test frame done");
		wreg(4'h6, 8'h07);
		repeat (2) @(posedge clock);
		#1;
		check("multiprocessor_enable", 1'b1, multiprocessor_enable);
		check("receiver_mode", 2'h3, rxm);
		check("autobaud", 1'b1, aben);
		wreg(4'h6, 8'h06);
		repeat (2) @(posedge clock);
		#1;
		check("multiprocessor_enable_off", 1'b0, multiprocessor_enable);
		wreg(4'hF, 8'h08);
		for (int w = 0; w < 4; w++) begin
			wreg(4'hA, {2'(w), 6'h00});
			sync_try(8'h20 - tol[w] - 8'h01, 1'b0, 1'b1);
			sync_try(8'h20 - tol[w], 1'b1, 1'b0);
			sync_try(8'h20 + tol[w], 1'b1, 1'b0);
			sync_try(8'h20 + tol[w] + 8'h01, 1'b0, 1'b1);
		end
		sync_try(8'h20, 1'b1, 1'b0);
		wreg(4'h6, 8'h04);
		sync_try(8'h00, 1'b0, 1'b1);
		sync_try(8'h50, 1'b1, 1'b0);
		wreg(4'h6, 8'h00);
		sync_try(8'h00, 1'b0, 1'b0);
		$display("test sync done");
		wreg(4'h8, 8'h03);
		wreg(4'h9, 8'h00);
		gap(1'b0, n);
		check("tick_gap", 16'd4, n);
		gap(1'b1, n);
		check("bit_gap", 16'd64, n);
		wreg(4'h9, 8'h01);
		wreg(4'h8, 8'h02);
		gap(1'b0, n);
		check("tick_gap16", 16'd259, n);
		rreg(4'h8, r);
		check("baud_lo", 8'h02, r);
		rreg(4'h9, r);
		check("baud_hi", 8'h01, r);
		wreg(4'h9, 8'h00);
		wreg(4'h8, 8'h03);
		$display("test baud done");
		wreg(4'hC, 8'h01);
		evt <= 1'b1;
		repeat (8) @(posedge clock);
		#1;
		check("ir_rx_on", 1'b1, irrx);
		@(posedge clock);
		halt <= 1'b1;
		wreg(4'h6, 8'h06);
		repeat (3) @(posedge clock);
		#1;
		check("halt_run", 1'b0, run);
		check("halt_evt", 1'b0, irrx);
		sync_try(8'h20, 1'b0, 1'b0);
		n = 0;
		repeat (40) begin
			@(negedge clock);
			n += stick;
		end
		check("halt_ticks", 16'd0, n);
		wreg(4'hB, 8'h01);
		repeat (3) @(posedge clock);
		#1;
		check("dbg_run", 1'b1, run);
		gap(1'b0, n);
		check("dbg_ticks", 16'd4, n);
		@(posedge clock);
		halt <= 1'b0;
		evt <= 1'b0;
		repeat (8) @(posedge clock);
		#1;
		check("ir_rx_low", 1'b0, irrx);
		wreg(4'hC, 8'h00);
		evt <= 1'b1;
		repeat (8) @(posedge clock);
		#1;
		check("ir_rx_off", 1'b0, irrx);
		$display("test debug event done");
		wreg(4'h7, 8'h03);
		wreg(4'hD, 8'h05);
		pass_run();
		wreg(4'h7, 8'h83);
		wreg(4'hD, 8'hFF);
		pass_run();
		@(posedge clock);
		bit_in <= 1'b0;
		wreg(4'hD, 8'h05);
		runlen(n);
		check("pulse_fixed", 16'd5, n);
		wreg(4'hD, 8'h00);
		runlen(n);
		check("pulse_316", 16'd12, n);
		$display("test infrared done");
		complete_run();
	end
endmodule : testbench
`default_nettype wire

/* File: usfc_baud_ir.sv */
// Baud prescaler, sample ticks and infrared transmit pulse shaper
`include "usfc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module usfc_baud_ir (
	input  wire logic clk,
	input  wire logic rst_n,
	usfc_link_if.gen  lk
);
	logic [15:0]         pre_q;  // Prescaler count
	logic [3:0]          smp_q;  // Sample within bit
	logic                tick_q; // Sample pulse
	logic                btk_q;  // Bit pulse
	usfc_pkg::usfc_irst_t st_q;  // Pulse state
	logic [7:0]          cnt_q;  // Pulse length left
	logic                txd_q;  // Shaped line
	logic                start;  // Baud clock rising edge
	logic                dec;    // Pulse count step

	// Prescaler, reloaded at once on a divisor write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pre_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else if (lk.reload) begin
			pre_q  <= lk.baud;
			tick_q <= 1'b0;
		end else if (lk.run) begin
			pre_q  <= (pre_q == 16'h0000) ? lk.baud : pre_q - 16'h0001;
			tick_q <= (pre_q == 16'h0000);
		end else begin
			tick_q <= 1'b0;
		end
	end

	// Sixteen samples per bit
	always_ff @(posedge clk) begin
		if (!rst_n || lk.reload) begin
			smp_q <= 4'h0;
			btk_q <= 1'b0;
		end else begin
			if (tick_q) smp_q <= smp_q + 4'h1;
			btk_q <= tick_q && (smp_q == `USFC_SMP_LAST);
		end
	end

	assign start = tick_q && (smp_q == 4'h0);
	assign dec   = (lk.tx_pulse_length == 8'h00) ? tick_q : 1'b1;

	// Pulse shaper: zero bits send a short pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q  <= usfc_pkg::IR_IDLE;
			cnt_q <= 8'h00;
			txd_q <= 1'b0;
		end else if (!lk.ir_mode || lk.tx_pulse_length == `USFC_TX_PULSE_LENGTH_PASS) begin
			st_q  <= usfc_pkg::IR_IDLE;
			txd_q <= lk.tx_bit;
		end else begin
			case (st_q)
				usfc_pkg::IR_IDLE: begin
					txd_q <= 1'b0;
					if (start && !lk.tx_bit) begin
						st_q  <= usfc_pkg::IR_PULSE;
						cnt_q <= (lk.tx_pulse_length == 8'h00) ? `USFC_IR_316 : lk.tx_pulse_length;
						txd_q <= 1'b1;
					end
				end
				usfc_pkg::IR_PULSE: begin
					if (dec) cnt_q <= cnt_q - 8'h01;
					if (dec && cnt_q == 8'h01) begin
						st_q  <= usfc_pkg::IR_IDLE;
						txd_q <= 1'b0;
					end
				end
				default: st_q <= usfc_pkg::IR_IDLE;
			endcase
		end
	end

	assign lk.sample_tick = tick_q;
	assign lk.bit_tick    = btk_q;
	assign lk.ir_txd      = txd_q;

	chk_bit_boundary: assert property (@(posedge clk) disable iff (!rst_n)
		(tick_q && smp_q == `USFC_SMP_LAST && lk.run && !lk.reload) |=> btk_q)
		else $error("bit tick missing after sixteenth sample");
	chk_ir_passthru: assert property (@(posedge clk) disable iff (!rst_n)
		(lk.ir_mode && lk.tx_pulse_length == `USFC_TX_PULSE_LENGTH_PASS) |=> txd_q == $past(lk.tx_bit))
		else $error("pass-through line does not follow tx bit");
endmodule : usfc_baud_ir
`default_nettype wire

/* File: usfc_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef USFC_DEFS_SVH
`define USFC_DEFS_SVH
// Register offsets
`define USFC_OFS_STATUS  4'h4
`define USFC_OFS_RXCTL   4'h6
`define USFC_OFS_FRAME   4'h7
`define USFC_OFS_BAUD_LO 4'h8
`define USFC_OFS_BAUD_HI 4'h9
`define USFC_OFS_ABWIN   4'hA
`define USFC_OFS_DBG     4'hB
`define USFC_OFS_EVIN    4'hC
`define USFC_OFS_TX_PULSE_LENGTH    4'hD
`define USFC_OFS_IMASK   4'hF
// Field positions
`define USFC_MULTIPROCESSOR_ENABLE_BIT    0
`define USFC_STOP_BIT    3
`define USFC_ORDER_BIT   2
`define USFC_PHASE_BIT   1
`define USFC_ISF_BIT     3
// Reset values, read masks and pass-through pulse code
`define USFC_FRAME_RST   8'h03
`define USFC_SPI_RD_MASK 8'hC6
`define USFC_TX_PULSE_LENGTH_PASS   8'hFF
// Timing counts in baud samples
`define USFC_SMP_LAST    4'hF
`define USFC_PAIR_NOM    8'h20
`define USFC_IR_316      8'h03
`define USFC_ABW_W0      8'h06
`define USFC_ABW_W1      8'h05
`define USFC_ABW_W2      8'h07
`define USFC_ABW_W3      8'h08
`endif

/* File: usfc_far_model.sv */
// Far-side partner: sync measurements, event channel and transmit bit
`timescale 1ns/10ps
`default_nettype none
module usfc_far_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       fire,       // Issue one measurement
	input  wire logic [7:0] len,        // Length to present
	input  wire logic       evt,        // Event channel level
	input  wire logic       bit_in,     // Bit for the transmit line
	output logic            sync_valid, // Measurement strobe
	output logic      [7:0] sync_len,   // Measured length
	output logic            ir_event,   // Event channel line
	output logic            tx_bit      // Transmit bit line
);
	// Length stands only with its strobe, scrambled otherwise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_valid <= 1'b0;
			sync_len   <= 8'h5A;
		end else begin
			sync_valid <= fire;
			sync_len   <= fire ? len : ~sync_len;
		end
	end
	// Event and bit lines follow the bench one cycle later
	always_ff @(posedge clk) begin
		ir_event <= evt;
		tx_bit   <= bit_in;
	end
endmodule : usfc_far_model
`default_nettype wire

/* File: usfc_link_if.sv */
// Signals between the register side and the baud and pulse generator
`timescale 1ns/10ps
`default_nettype none
interface usfc_link_if;
	logic [15:0] baud;        // Divisor
	logic        reload;      // Prescaler reload pulse
	logic        run;         // Not halted
	logic        ir_mode;     // Infrared selected
	logic [7:0]  tx_pulse_length;        // Pulse length code
	logic        tx_bit;      // Serial bit to send
	logic        sample_tick; // 16x sample pulse
	logic        bit_tick;    // Bit boundary pulse
	logic        ir_txd;      // Shaped transmit line
	modport ctl (output baud, reload, run, ir_mode, tx_pulse_length, tx_bit,
		input sample_tick, bit_tick, ir_txd);
	modport gen (input baud, reload, run, ir_mode, tx_pulse_length, tx_bit,
		output sample_tick, bit_tick, ir_txd);
endinterface : usfc_link_if
`default_nettype wire

/* File: usfc_pkg.sv */
// Mode and state types of the frame and baud configuration block
`default_nettype none
package usfc_pkg;
	// Communication modes
	typedef enum logic [1:0] {
		CM_ASYNC = 2'h0,
		CM_SYNC  = 2'h1,
		CM_IR    = 2'h2,
		CM_SPI   = 2'h3
	} usfc_communication_mode_select_t;
	// Receiver modes
	typedef enum logic [1:0] {
		RX_NORMAL  = 2'h0,
		RX_DOUBLE  = 2'h1,
		RX_GENAUTO = 2'h2,
		RX_LIN_CONSTRAINED_AUTOBAUD = 2'h3
	} usfc_receiver_mode_t;
	// Infrared pulse states
	typedef enum logic {
		IR_IDLE  = 1'b0,
		IR_PULSE = 1'b1
	} usfc_irst_t;
endpackage : usfc_pkg
`default_nettype wire

/* File: usfc_top.sv */
// Frame, baud, auto-baud window, debug and infrared configuration block
//
// The plain strobed port was decided locally.
`include "usfc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module usfc_top (
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	input  wire logic [3:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	output logic             IRQ,
	input  wire logic        DEBUG_HALT,
	input  wire logic        SYNC_VALID,
	input  wire logic [7:0]  SYNC_LEN,
	input  wire logic        IR_EVENT_IN,
	input  wire logic        TX_BIT,
	output logic             MULTIPROCESSOR_ENABLE_EN,
	output logic      [1:0]  RX_MODE,
	output logic      [1:0]  COMM_MODE,
	output logic             SPI_MODE,
	output logic             IR_MODE,
	output logic             PARITY_EN,
	output logic             PARITY_ODD,
	output logic             STOP_TWO,
	output logic      [3:0]  DATA_BITS,
	output logic             NINE_HIGH_FIRST,
	output logic             SPI_LSB_FIRST,
	output logic             SPI_SAMPLE_TRAIL,
	output logic             AUTOBAUD_EN,
	output logic             SYNC_ACCEPT,
	output logic             RUN_EN,
	output logic             IR_RX_IN,
	output logic             SAMPLE_TICK,
	output logic             BIT_TICK,
	output logic             IR_TXD
);
	// Register storage
	logic        multiprocessor_enable_q;   // Multiprocessor enable
	logic [1:0]  rxm_q;    // Receiver mode
	logic [7:0]  frame_q;  // Frame format byte
	logic [15:0] baud_q;   // Baud divisor
	logic [1:0]  abw_q;    // Auto-baud window
	logic        dbg_q;    // Keep running in debug
	logic        evin_q;   // Event input enable
	logic [7:0]  tx_pulse_length_q;   // Pulse length code
	logic        isf_q;    // Inconsistent sync flag
	logic        imask_q;  // Interrupt mask
	logic        reload_q; // Prescaler reload pulse
	logic [7:0]  rdata_q;  // Read data
	logic        irq_q;    // Interrupt level

	// Decoded outputs
	logic        spi_q;    // Host SPI layout
	logic        ir_q;     // Infrared mode
	logic        pen_q;    // Parity on
	logic        podd_q;   // Odd parity
	logic        stop2_q;  // Two stops
	logic [3:0]  dbits_q;  // Data bits
	logic        nhf_q;    // Nine bits high first
	logic        lsbf_q;   // SPI LSb first
	logic        trail_q;  // SPI trailing sample
	logic        aben_q;   // Auto-baud on
	logic        acc_q;    // Sync accepted pulse
	logic        run_q;    // Not halted
	logic        ev1_q;    // Event sync stage one
	logic        ev2_q;    // Event sync stage two
	logic        irin_q;   // Gated event input

	// Combinational helpers
	logic        run;      // Block may advance
	logic [1:0]  communication_mode_select;    // Mode field
	logic [7:0]  win;      // Window half width
	logic        in_win;   // Length within window
	logic        sync_ok;  // Sync gives a valid rate
	logic        sync_ev;  // Sync event taken
	logic        isf_set;  // Flag set event
	logic        isf_clr;  // Flag clear by write

	usfc_link_if lk ();

	// Halt only when debug halts and run bit is clear
	assign run   = !(DEBUG_HALT && !dbg_q);
	assign communication_mode_select = frame_q[7:6];

	// Control byte: multiprocessor and receiver mode
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			multiprocessor_enable_q <= 1'b0;
			rxm_q  <= 2'h0;
		end else if (WR && ADDR == `USFC_OFS_RXCTL) begin
			multiprocessor_enable_q <= WDATA[`USFC_MULTIPROCESSOR_ENABLE_BIT];
			rxm_q  <= WDATA[2:1];
		end
	end

	// Frame format byte; layout follows the mode field
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			frame_q <= `USFC_FRAME_RST;
		end else if (WR && ADDR == `USFC_OFS_FRAME) begin
			frame_q <= WDATA;
		end
	end

	// Divisor bytes; any write reloads the prescaler
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			baud_q   <= 16'h0000;
			reload_q <= 1'b0;
		end else begin
			reload_q <= 1'b0;
			if (WR && ADDR == `USFC_OFS_BAUD_LO) begin
				baud_q[7:0] <= WDATA;
				reload_q    <= 1'b1;
			end
			if (WR && ADDR == `USFC_OFS_BAUD_HI) begin
				baud_q[15:8] <= WDATA;
				reload_q     <= 1'b1;
			end
		end
	end

	// Window, debug, event and pulse length bytes
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			abw_q  <= 2'h0;
			dbg_q  <= 1'b0;
			evin_q <= 1'b0;
			tx_pulse_length_q <= 8'h00;
		end else if (WR) begin
			case (ADDR)
				`USFC_OFS_ABWIN: abw_q  <= WDATA[7:6];
				`USFC_OFS_DBG:   dbg_q  <= WDATA[0];
				`USFC_OFS_EVIN:  evin_q <= WDATA[0];
				`USFC_OFS_TX_PULSE_LENGTH:  tx_pulse_length_q <= WDATA;
				default: begin
				end
			endcase
		end
	end

	// Interrupt mask, same layout as status
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			imask_q <= 1'b0;
		end else if (WR && ADDR == `USFC_OFS_IMASK) begin
			imask_q <= WDATA[`USFC_ISF_BIT];
		end
	end

	// Window half width per setting
	always_comb begin
		case (abw_q)
			2'h0:    win = `USFC_ABW_W0;
			2'h1:    win = `USFC_ABW_W1;
			2'h2:    win = `USFC_ABW_W2;
			default: win = `USFC_ABW_W3;
		endcase
	end

	// Nominal pair of two 16-sample bits, plus or minus window
	assign in_win  = (SYNC_LEN >= `USFC_PAIR_NOM - win) &&
		(SYNC_LEN <= `USFC_PAIR_NOM + win);
	// Window only in LIN mode; generic mode rejects zero
	assign sync_ok = (rxm_q == usfc_pkg::RX_LIN_CONSTRAINED_AUTOBAUD) ? in_win :
		(SYNC_LEN != 8'h00);
	// Events are ignored while halted
	assign sync_ev = SYNC_VALID && run && rxm_q[1];
	assign isf_set = sync_ev && !sync_ok;
	assign isf_clr = WR && ADDR == `USFC_OFS_STATUS && WDATA[`USFC_ISF_BIT];

	// Sticky flag; a new event beats the clear
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			isf_q <= 1'b0;
		end else if (isf_set) begin
			isf_q <= 1'b1;
		end else if (isf_clr) begin
			isf_q <= 1'b0;
		end
	end

	// Accept pulse and auto-baud enable
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			acc_q  <= 1'b0;
			aben_q <= 1'b0;
		end else begin
			acc_q  <= sync_ev && sync_ok;
			aben_q <= rxm_q[1];
		end
	end

	// Mode decode
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			spi_q <= 1'b0;
			ir_q  <= 1'b0;
		end else begin
			spi_q <= (communication_mode_select == usfc_pkg::CM_SPI);
			ir_q  <= (communication_mode_select == usfc_pkg::CM_IR);
		end
	end

	// Framing decode, forced off in SPI layout
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			pen_q   <= 1'b0;
			podd_q  <= 1'b0;
			stop2_q <= 1'b0;
		end else begin
			// Reserved parity code acts as none
			pen_q   <= (communication_mode_select != usfc_pkg::CM_SPI) && frame_q[5];
			podd_q  <= (communication_mode_select != usfc_pkg::CM_SPI) && frame_q[5] && frame_q[4];
			// Receiver ignores this; transmitter only
			stop2_q <= (communication_mode_select != usfc_pkg::CM_SPI) && frame_q[`USFC_STOP_BIT];
		end
	end

	// Character length for both directions
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			dbits_q <= 4'h8;
			nhf_q   <= 1'b0;
		end else begin
			case (frame_q[2:0])
				3'h0:    dbits_q <= 4'h5;
				3'h1:    dbits_q <= 4'h6;
				3'h2:    dbits_q <= 4'h7;
				3'h6,
				3'h7:    dbits_q <= 4'h9;
				// Reserved codes fall back to eight
				default: dbits_q <= 4'h8;
			endcase
			nhf_q <= (frame_q[2:0] == 3'h7);
		end
	end

	// SPI order and phase; no guard for mid-transfer changes
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			lsbf_q  <= 1'b0;
			trail_q <= 1'b0;
		end else begin
			lsbf_q  <= (communication_mode_select == usfc_pkg::CM_SPI) && frame_q[`USFC_ORDER_BIT];
			trail_q <= (communication_mode_select == usfc_pkg::CM_SPI) && frame_q[`USFC_PHASE_BIT];
		end
	end

	// Event input: two-stage sync, then gate
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			ev1_q  <= 1'b0;
			ev2_q  <= 1'b0;
			irin_q <= 1'b0;
			run_q  <= 1'b1;
		end else begin
			ev1_q  <= IR_EVENT_IN;
			ev2_q  <= ev1_q;
			irin_q <= ev2_q && evin_q && run;
			run_q  <= run;
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			rdata_q <= 8'h00;
		end else if (RD) begin
			case (ADDR)
				`USFC_OFS_STATUS:  rdata_q <= {4'h0, isf_q, 3'h0};
				`USFC_OFS_RXCTL:   rdata_q <= {5'h00, rxm_q, multiprocessor_enable_q};
				`USFC_OFS_FRAME:   rdata_q <= (communication_mode_select == usfc_pkg::CM_SPI) ?
					(frame_q & `USFC_SPI_RD_MASK) : frame_q;
				`USFC_OFS_BAUD_LO: rdata_q <= baud_q[7:0];
				`USFC_OFS_BAUD_HI: rdata_q <= baud_q[15:8];
				`USFC_OFS_ABWIN:   rdata_q <= {abw_q, 6'h00};
				`USFC_OFS_DBG:     rdata_q <= {7'h00, dbg_q};
				`USFC_OFS_EVIN:    rdata_q <= {7'h00, evin_q};
				`USFC_OFS_TX_PULSE_LENGTH:    rdata_q <= tx_pulse_length_q;
				`USFC_OFS_IMASK:   rdata_q <= {4'h0, imask_q, 3'h0};
				default:           rdata_q <= 8'h00;
			endcase
		end
	end

	// Level interrupt from unmasked flag
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= isf_q && imask_q;
		end
	end

	// Generator link
	assign lk.baud    = baud_q;
	assign lk.reload  = reload_q;
	assign lk.run     = run_q;
	assign lk.ir_mode = ir_q;
	assign lk.tx_pulse_length    = tx_pulse_length_q;
	assign lk.tx_bit  = TX_BIT;

	// Baud and pulse generator
	usfc_baud_ir u_gen (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.lk    (lk)
	);

	// Output ports
	assign RDATA            = rdata_q;
	assign IRQ              = irq_q;
	assign MULTIPROCESSOR_ENABLE_EN          = multiprocessor_enable_q;
	assign RX_MODE          = rxm_q;
	assign COMM_MODE        = frame_q[7:6];
	assign SPI_MODE         = spi_q;
	assign IR_MODE          = ir_q;
	assign PARITY_EN        = pen_q;
	assign PARITY_ODD       = podd_q;
	assign STOP_TWO         = stop2_q;
	assign DATA_BITS        = dbits_q;
	assign NINE_HIGH_FIRST  = nhf_q;
	assign SPI_LSB_FIRST    = lsbf_q;
	assign SPI_SAMPLE_TRAIL = trail_q;
	assign AUTOBAUD_EN      = aben_q;
	assign SYNC_ACCEPT      = acc_q;
	assign RUN_EN           = run_q;
	assign IR_RX_IN         = irin_q;
	assign SAMPLE_TICK      = lk.sample_tick;
	assign BIT_TICK         = lk.bit_tick;
	assign IR_TXD           = lk.ir_txd;

	// Checks
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	sequence s_frame_wr;
		WR && ADDR == `USFC_OFS_FRAME;
	endsequence
	sequence s_lin_sync;
		SYNC_VALID && run && rxm_q == usfc_pkg::RX_LIN_CONSTRAINED_AUTOBAUD;
	endsequence

	chk_multiprocessor_enable_write: assert property ((WR && ADDR == `USFC_OFS_RXCTL)
		|=> MULTIPROCESSOR_ENABLE_EN == $past(WDATA[0]))
		else $error("multiprocessor enable not taken from write");
	chk_mode_decode: assert property (s_frame_wr ##1 1
		|=> {IR_MODE, SPI_MODE} == {$past(communication_mode_select) == 2'h2, $past(communication_mode_select) == 2'h3})
		else $error("mode decode wrong after frame write");
	chk_spi_layout: assert property ((RD && ADDR == `USFC_OFS_FRAME && communication_mode_select == 2'h3)
		|=> (RDATA & ~`USFC_SPI_RD_MASK) == 8'h00)
		else $error("SPI layout shows framing bits");
	chk_parity_spi: assert property (s_frame_wr ##1 1
		|=> PARITY_EN == ($past(communication_mode_select) != 2'h3 && $past(frame_q[5])))
		else $error("parity enable wrong");
	chk_nine_bits: assert property ((frame_q[2:1] == 2'h3 && $stable(frame_q))
		|=> DATA_BITS == 4'h9)
		else $error("nine-bit length not decoded");
	chk_baud_reload: assert property ((WR && ADDR == `USFC_OFS_BAUD_HI)
		|=> reload_q ##1 !SAMPLE_TICK)
		else $error("divisor write did not reload prescaler");
	chk_window_hit: assert property ((s_lin_sync and SYNC_LEN == `USFC_PAIR_NOM)
		|=> SYNC_ACCEPT && isf_q == $past(isf_q && !isf_clr))
		else $error("nominal pair length rejected");
	chk_window_miss: assert property ((s_lin_sync and SYNC_LEN == 8'h29)
		|=> isf_q ##1 IRQ == $past(imask_q))
		else $error("out-of-window sync not flagged");
	chk_debug_halt: assert property ((DEBUG_HALT && !dbg_q && SYNC_VALID)
		|=> !RUN_EN && !SYNC_ACCEPT)
		else $error("block ran or took event in debug halt");
	chk_event_gate: assert property (!evin_q |=> !IR_RX_IN)
		else $error("event input passed while disabled");
endmodule : usfc_top
`default_nettype wire
